// >>> src/hbdt_pkg.sv
// constants and types for the half-bridge deadtime and safe-start block
package hbdt_pkg;
    localparam int unsigned CLK_MHZ = 250;
    localparam int unsigned DT_MIN_NS = 230;
    localparam int unsigned DT_MAX_NS = 700;
    localparam int unsigned IDLE_US = 50;
    localparam int unsigned SYNC_PHASE_US = 50;
    // least time rounds up, longest time rounds down
    localparam int unsigned DT_MIN_CYC = (DT_MIN_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned DT_MAX_CYC = (DT_MAX_NS * CLK_MHZ) / 1000;
    localparam int unsigned IDLE_CYC = IDLE_US * CLK_MHZ;
    localparam int unsigned SYNC_PHASE_CYC = SYNC_PHASE_US * CLK_MHZ;
    localparam int unsigned PRECHARGE_CYC = 2500;
    localparam int unsigned HALF_PERIOD_CYC = 1250;
    localparam int unsigned CNT_W = 16;

    typedef enum logic [5:0] {
        HBDT_OFF = 6'h01,
        HBDT_PRECHARGE = 6'h02,
        HBDT_IDLE = 6'h04,
        HBDT_LOW_ON = 6'h08,
        HBDT_DEAD = 6'h10,
        HBDT_HIGH_ON = 6'h20
    } hbdt_state_t;
endpackage

// >>> src/hbdt_sync_edge.sv
// two-flop synchroniser with falling-edge pulse for the swing sensor
`timescale 1ns/10ps
module hbdt_sync_edge (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_async,
    output logic o_level,
    output logic o_fall
);
    logic meta;
    logic sync;
    logic prev;

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta <= 1'b0;
            sync <= 1'b0;
            prev <= 1'b0;
        end else begin
            meta <= i_async;
            sync <= meta;
            prev <= sync;
        end
    end

    assign o_level = sync;
    // one-cycle pulse on the end of the midpoint swing
    assign o_fall = prev & ~sync;
endmodule

// >>> src/hbdt_core.sv
// adaptive deadtime and safe-start sequencer for a half-bridge
`timescale 1ns/10ps
// Overview of operation
// - deadtime at least about 230 ns unless period/4 is shorter
// - deadtime capped at min(700 ns, period/4)
// - max deadtime timed from outgoing gate fall
// - swing end raises complementary gate after delay
// - sensor high during swing, fall pulse ends
// - low side held on for pre-charge first
// - both gates off about 50 us after
// - alternate gates, symmetric 50 percent duty
// - initial cycles: current reverses every half-cycle
// - low side switches first on start
// - sync to zero-crossings, normal after 50 us
module hbdt_core #(
    parameter int unsigned PRECHARGE_CYC = hbdt_pkg::PRECHARGE_CYC,
    parameter int unsigned IDLE_CYC = hbdt_pkg::IDLE_CYC,
    parameter int unsigned SYNC_PHASE_CYC = hbdt_pkg::SYNC_PHASE_CYC,
    parameter int unsigned DT_MIN_CYC = hbdt_pkg::DT_MIN_CYC,
    parameter int unsigned DT_MAX_CYC = hbdt_pkg::DT_MAX_CYC
) (
    input wire logic i_core_clk,
    input wire logic i_resetn,
    input wire logic i_enable,
    input wire logic [15:0] i_half_period,
    input wire logic i_midpoint_swing_sensor,
    input wire logic i_tank_zero_cross,
    output logic o_high_side_gate_drive,
    output logic o_low_side_gate_drive,
    output logic o_oscillator_ramp,
    output logic o_sync_phase,
    output logic o_running
);
    localparam int W = hbdt_pkg::CNT_W;

    hbdt_pkg::hbdt_state_t state;
    hbdt_pkg::hbdt_state_t next_state;
    logic [W-1:0] cnt;
    logic [W-1:0] ph_cnt;
    logic [W-1:0] sync_cnt;
    logic [W-1:0] hp;
    logic [W-1:0] dt_max;
    logic next_high;
    logic en_meta, en_sync;
    logic zc_meta, zc_sync, zc_prev;
    logic zc_edge;
    logic swing_end;
    logic swing_seen;
    logic pre_done;
    logic dt_done;
    logic half_done;

    function automatic logic [W-1:0] min_cnt(input logic [W-1:0] a,
                                              input logic [W-1:0] b);
        return (a < b) ? a : b;
    endfunction

    hbdt_sync_edge u_swing (
        .i_core_clk(i_core_clk),
        .i_resetn(i_resetn),
        .i_async(i_midpoint_swing_sensor),
        .o_level(),
        .o_fall(swing_end)
    );

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
            zc_meta <= 1'b0;
            zc_sync <= 1'b0;
            zc_prev <= 1'b0;
        end else begin
            en_meta <= i_enable;
            en_sync <= en_meta;
            zc_meta <= i_tank_zero_cross;
            zc_sync <= zc_meta;
            zc_prev <= zc_sync;
        end
    end

    assign zc_edge = zc_sync ^ zc_prev;

    // half period held through each deadtime so a swing never sees a step
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            hp <= W'(hbdt_pkg::HALF_PERIOD_CYC);
        end else if (state != hbdt_pkg::HBDT_DEAD) begin
            hp <= (i_half_period < 16'h0004) ? 16'h0004 : i_half_period;
        end
    end

    // quarter of the full period is half of a half period
    assign dt_max = min_cnt(W'(DT_MAX_CYC), hp >> 1);

    // deadtime ends on swing end once the floor is met, or at the cap
    assign dt_done = (cnt + 1'b1 >= dt_max) ||
        ((swing_end || swing_seen) &&
         (cnt + 1'b1 >= W'(DT_MIN_CYC)));

    // an early swing end is held until the deadtime floor is reached
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) swing_seen <= 1'b0;
        else if (state != hbdt_pkg::HBDT_DEAD) swing_seen <= 1'b0;
        else if (swing_end) swing_seen <= 1'b1;
    end

    // in the sync phase the tank current reversal ends a half-cycle early;
    // the oscillator length still bounds it if no reversal is seen
    assign half_done = (o_sync_phase && zc_edge && ph_cnt != '0) ||
        (ph_cnt + 1'b1 >= hp);

    always_comb begin
        next_state = state;
        case (state)
            hbdt_pkg::HBDT_OFF: begin
                if (en_sync) next_state = hbdt_pkg::HBDT_PRECHARGE;
            end
            hbdt_pkg::HBDT_PRECHARGE: begin
                if (cnt + 1'b1 >= W'(PRECHARGE_CYC)) begin
                    next_state = hbdt_pkg::HBDT_IDLE;
                end
            end
            hbdt_pkg::HBDT_IDLE: begin
                if (cnt + 1'b1 >= W'(IDLE_CYC)) begin
                    next_state = hbdt_pkg::HBDT_LOW_ON;
                end
            end
            hbdt_pkg::HBDT_LOW_ON: begin
                if (half_done) next_state = hbdt_pkg::HBDT_DEAD;
            end
            hbdt_pkg::HBDT_DEAD: begin
                if (dt_done) begin
                    next_state = next_high ? hbdt_pkg::HBDT_HIGH_ON
                                           : hbdt_pkg::HBDT_LOW_ON;
                end
            end
            hbdt_pkg::HBDT_HIGH_ON: begin
                if (half_done) next_state = hbdt_pkg::HBDT_DEAD;
            end
            default: next_state = hbdt_pkg::HBDT_OFF;
        endcase
        if (!en_sync) next_state = hbdt_pkg::HBDT_OFF;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) state <= hbdt_pkg::HBDT_OFF;
        else state <= next_state;
    end

    // interval counter restarts at every state change
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) cnt <= '0;
        else if (next_state != state) cnt <= '0;
        else if (cnt != '1) cnt <= cnt + 1'b1;
    end

    // phase counter spans each half-cycle including its deadtime
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) ph_cnt <= '0;
        else if (state == hbdt_pkg::HBDT_OFF ||
                 state == hbdt_pkg::HBDT_PRECHARGE ||
                 state == hbdt_pkg::HBDT_IDLE) ph_cnt <= '0;
        else if (next_state == hbdt_pkg::HBDT_DEAD &&
                 state != hbdt_pkg::HBDT_DEAD) ph_cnt <= '0;
        else if (ph_cnt != '1) ph_cnt <= ph_cnt + 1'b1;
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) next_high <= 1'b0;
        else if (state == hbdt_pkg::HBDT_LOW_ON) next_high <= 1'b1;
        else if (state == hbdt_pkg::HBDT_HIGH_ON) next_high <= 1'b0;
        else if (state == hbdt_pkg::HBDT_IDLE) next_high <= 1'b0;
    end

    // sync phase lasts a fixed time from the first switching cycle
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            sync_cnt <= '0;
            o_sync_phase <= 1'b0;
        end else if (state == hbdt_pkg::HBDT_IDLE) begin
            sync_cnt <= '0;
            o_sync_phase <= 1'b1;
        end else if (state == hbdt_pkg::HBDT_OFF) begin
            o_sync_phase <= 1'b0;
        end else if (o_sync_phase) begin
            sync_cnt <= sync_cnt + 1'b1;
            if (sync_cnt + 1'b1 >= W'(SYNC_PHASE_CYC)) begin
                o_sync_phase <= 1'b0;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_low_side_gate_drive <= 1'b0;
            o_high_side_gate_drive <= 1'b0;
            o_oscillator_ramp <= 1'b0;
            o_running <= 1'b0;
        end else begin
            o_low_side_gate_drive <=
                next_state == hbdt_pkg::HBDT_PRECHARGE ||
                next_state == hbdt_pkg::HBDT_LOW_ON;
            o_high_side_gate_drive <= next_state == hbdt_pkg::HBDT_HIGH_ON;
            // ramp up while the low side leads, down for the high side
            o_oscillator_ramp <= (next_state == hbdt_pkg::HBDT_LOW_ON) ||
                (next_state == hbdt_pkg::HBDT_DEAD && !next_high) ||
                (next_state == hbdt_pkg::HBDT_DEAD && state ==
                 hbdt_pkg::HBDT_LOW_ON);
            o_running <= next_state == hbdt_pkg::HBDT_LOW_ON ||
                next_state == hbdt_pkg::HBDT_DEAD ||
                next_state == hbdt_pkg::HBDT_HIGH_ON;
        end
    end

    // helper: gates-off time counted since either gate fell
    logic [W-1:0] off_cnt;
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) off_cnt <= '0;
        else if (o_low_side_gate_drive || o_high_side_gate_drive) begin
            off_cnt <= '0;
        end else if (off_cnt != '1) off_cnt <= off_cnt + 1'b1;
    end

    // helper: a full pre-charge has run since the block was last off
    always_ff @(posedge i_core_clk or negedge i_resetn) begin
        if (!i_resetn) pre_done <= 1'b0;
        else if (state == hbdt_pkg::HBDT_OFF) pre_done <= 1'b0;
        else if (state == hbdt_pkg::HBDT_PRECHARGE &&
                 cnt + 1'b1 >= W'(PRECHARGE_CYC)) pre_done <= 1'b1;
    end

    property p_no_overlap;
        @(posedge i_core_clk) disable iff (!i_resetn)
        !(o_low_side_gate_drive && o_high_side_gate_drive);
    endproperty
    a_no_overlap: assert property (p_no_overlap)
        else $error("both gate drives on");

    property p_dt_min;
        @(posedge i_core_clk) disable iff (!i_resetn)
        $rose(o_high_side_gate_drive) |->
            $past(off_cnt) + 1'b1 >= W'(DT_MIN_CYC);
    endproperty
    a_dt_min: assert property (p_dt_min)
        else $error("deadtime below minimum");

    property p_dt_max;
        @(posedge i_core_clk) disable iff (!i_resetn)
        state == hbdt_pkg::HBDT_DEAD |-> cnt < dt_max;
    endproperty
    a_dt_max: assert property (p_dt_max)
        else $error("deadtime exceeded cap");

    property p_cap_on;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (state == hbdt_pkg::HBDT_DEAD && cnt + 1'b1 >= dt_max && en_sync)
            |=> (state != hbdt_pkg::HBDT_DEAD);
    endproperty
    a_cap_on: assert property (p_cap_on)
        else $error("cap expiry did not turn on gate");

    property p_swing_end;
        @(posedge i_core_clk) disable iff (!i_resetn)
        (state == hbdt_pkg::HBDT_DEAD && swing_end && en_sync &&
         cnt + 1'b1 >= W'(DT_MIN_CYC)) |=> ##1
            (o_low_side_gate_drive || o_high_side_gate_drive);
    endproperty
    a_swing_end: assert property (p_swing_end)
        else $error("swing end did not raise gate");

    property p_first_low;
        @(posedge i_core_clk) disable iff (!i_resetn)
        $rose(o_running) |-> o_low_side_gate_drive;
    endproperty
    a_first_low: assert property (p_first_low)
        else $error("high side switched first");

    property p_idle_off;
        @(posedge i_core_clk) disable iff (!i_resetn)
        state == hbdt_pkg::HBDT_IDLE |=>
            !o_high_side_gate_drive && (o_low_side_gate_drive ->
             state == hbdt_pkg::HBDT_LOW_ON);
    endproperty
    a_idle_off: assert property (p_idle_off)
        else $error("gate on during idle");

    property p_precharge;
        @(posedge i_core_clk) disable iff (!i_resetn)
        $rose(o_high_side_gate_drive) |-> pre_done;
    endproperty
    a_precharge: assert property (p_precharge)
        else $error("high side before pre-charge");
endmodule

// >>> testbench/hbdt_bridge_model.sv
// behavioural half-bridge power stage with swing sensor and tank current
`timescale 1ns/10ps
module hbdt_bridge_model (
    input wire logic i_core_clk,
    input wire logic i_high_side_gate_drive,
    input wire logic i_low_side_gate_drive,
    input wire logic [15:0] i_swing_cyc,
    input wire logic [15:0] i_zc_cyc,
    output logic o_midpoint_swing_sensor,
    output logic o_tank_zero_cross
);
    logic prev_h = 1'b0;
    logic prev_l = 1'b0;
    int sw_cnt = 0;
    int zc_cnt = 0;
    initial o_midpoint_swing_sensor = 1'b0;
    initial o_tank_zero_cross = 1'b0;
    // two cycles of turn-off delay, then the midpoint swings; zero length
    // means no swing is ever sensed
    always @(posedge i_core_clk) begin
        prev_h <= i_high_side_gate_drive;
        prev_l <= i_low_side_gate_drive;
        if ((prev_h && !i_high_side_gate_drive) ||
            (prev_l && !i_low_side_gate_drive)) begin
            sw_cnt <= (i_swing_cyc == 16'h0000) ? 0 : int'(i_swing_cyc) + 2;
        end else if (sw_cnt > 0) begin
            sw_cnt <= sw_cnt - 1;
        end
        o_midpoint_swing_sensor <= sw_cnt > 1 &&
            sw_cnt <= i_swing_cyc + 1;
    end
    // tank current reverses a fixed time after each turn-on
    always @(posedge i_core_clk) begin
        if ((!prev_h && i_high_side_gate_drive) ||
            (!prev_l && i_low_side_gate_drive)) begin
            zc_cnt <= int'(i_zc_cyc);
        end else if (zc_cnt > 0) begin
            zc_cnt <= zc_cnt - 1;
            if (zc_cnt == 1) begin
                o_tank_zero_cross <= ~o_tank_zero_cross;
            end
        end
    end
endmodule

// >>> testbench/half_bridge_deadtime_safe_start_test.sv
// self-checking bench for the half-bridge deadtime and safe-start block
`timescale 1ns/10ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin \
    mismatches++; $display("CHECK FAILED t=%0t got %0h exp %0h", \
    $time, (g), (e)); end end
module half_bridge_deadtime_safe_start_test;
    localparam int PRE = 20;
    localparam int IDL = 40;
    localparam int SYN = 200;
    logic i_core_clk = 1'b0;
    logic i_resetn = 1'b0;
    logic i_enable = 1'b0;
    logic [15:0] i_half_period = 16'h0190;
    logic [15:0] swing = 16'h0014;
    logic [15:0] zc = 16'h001E;
    logic sensor, zcross, hs, ls, ramp, syncp, run;
    logic ph = 1'b0;
    logic pl = 1'b0;
    int mismatches = 0;
    int comparisons = 0;
    int cyc = 0, dt_cnt = 0, dt_lo = 0, dt_hi = 0, overlap = 0;
    int h_cnt = 0, l_cnt = 0, hi_on = 0, lo_on = 0, run_start = 0;

    always #2 i_core_clk = ~i_core_clk;

    hbdt_core #(.PRECHARGE_CYC(PRE), .IDLE_CYC(IDL),
        .SYNC_PHASE_CYC(SYN)) u_dut (
        .i_core_clk(i_core_clk), .i_resetn(i_resetn),
        .i_enable(i_enable), .i_half_period(i_half_period),
        .i_midpoint_swing_sensor(sensor), .i_tank_zero_cross(zcross),
        .o_high_side_gate_drive(hs), .o_low_side_gate_drive(ls),
        .o_oscillator_ramp(ramp), .o_sync_phase(syncp), .o_running(run));

    hbdt_bridge_model u_bridge (.i_core_clk(i_core_clk),
        .i_high_side_gate_drive(hs), .i_low_side_gate_drive(ls),
        .i_swing_cyc(swing), .i_zc_cyc(zc),
        .o_midpoint_swing_sensor(sensor), .o_tank_zero_cross(zcross));

    // on-times and deadtimes in whole cycles, sampled at the falling edge
    always @(negedge i_core_clk) begin
        cyc++;
        if (hs && ls) overlap++;
        if (hs) h_cnt++;
        if (ls) l_cnt++;
        if (ph && !hs) begin hi_on = h_cnt; h_cnt = 0; end
        if (pl && !ls) begin lo_on = l_cnt; l_cnt = 0; end
        if ((ph && !hs) || (pl && !ls)) dt_cnt = 1;
        else if (dt_cnt > 0 && !hs && !ls) dt_cnt++;
        else if (dt_cnt > 0) begin
            if (dt_cnt < dt_lo) dt_lo = dt_cnt;
            if (dt_cnt > dt_hi) dt_hi = dt_cnt;
            dt_cnt = 0;
        end
        ph = hs;
        pl = ls;
    end

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // monitor results have landed by the time this returns
    task automatic step;
        @(negedge i_core_clk);
        #1;
    endtask

    task automatic wait_gate(input bit hi, input bit lvl);
        int n;
        n = 0;
        while (((hi ? hs : ls) !== lvl) && n < 2000) begin step; n++; end
        `CHK(n < 2000, 1'b1)
    endtask

    task automatic t_startup;
        int n;
        bit hs_seen;
        @(negedge i_core_clk);
        i_enable = 1'b1;
        wait_gate(0, 1);
        `CHK(hs, 1'b0)
        n = 0;
        while (ls === 1'b1 && n < 500) begin step; n++; end
        `CHK(n >= PRE && n <= PRE + 1, 1'b1)
        n = 0;
        hs_seen = 1'b0;
        while (ls !== 1'b1 && n < 500) begin hs_seen |= hs; step; n++; end
        `CHK(n >= IDL && n <= IDL + 2, 1'b1)
        `CHK(hs_seen, 1'b0)
        `CHK(ramp, 1'b1)
        `CHK(run, 1'b1)
        run_start = cyc;
        $display("startup test done");
    endtask

    task automatic t_sync;
        `CHK(syncp, 1'b1)
        wait_gate(0, 0);
        `CHK(lo_on >= 30 && lo_on <= 40, 1'b1)
        wait_gate(1, 1);
        wait_gate(1, 0);
        `CHK(hi_on >= 30 && hi_on <= 40, 1'b1)
        $display("sync test done");
    endtask

    task automatic t_sync_end;
        int n;
        n = 0;
        while (syncp === 1'b1 && n < 3000) begin step; n++; end
        n = cyc - run_start;
        `CHK(n >= SYN && n <= SYN + 800, 1'b1)
        $display("sync end test done");
    endtask

    task automatic t_duty;
        repeat (2) begin
            wait_gate(0, 1);
            wait_gate(0, 0);
            wait_gate(1, 1);
            wait_gate(1, 0);
        end
        `CHK(hi_on, lo_on)
        `CHK(hi_on > 300 && hi_on < 400, 1'b1)
        wait_gate(1, 1);
        `CHK(ramp, 1'b0)
        $display("duty test done");
    endtask

    task automatic measure_dt(input logic [15:0] sw);
        swing = sw;
        wait_gate(0, 1);
        dt_lo = 100000;
        dt_hi = 0;
        overlap = 0;
        wait_gate(1, 1);
        wait_gate(0, 1);
    endtask

    task automatic t_dt_prompt;
        measure_dt(16'h0005);
        `CHK(dt_lo >= hbdt_pkg::DT_MIN_CYC, 1'b1)
        `CHK(overlap, 0)
        `CHK(dt_hi, int'(hbdt_pkg::DT_MIN_CYC))
        $display("prompt swing test done");
    endtask

    task automatic t_dt_slow;
        measure_dt(16'h0064);
        `CHK(dt_lo >= 100 && dt_hi <= 110, 1'b1)
        $display("slow swing test done");
    endtask

    task automatic t_dt_cap;
        measure_dt(16'h0000);
        `CHK(dt_lo >= 173 && dt_hi <= hbdt_pkg::DT_MAX_CYC, 1'b1)
        $display("absolute cap test done");
    endtask

    task automatic t_dt_period;
        @(negedge i_core_clk);
        i_half_period = 16'h00C8;
        measure_dt(16'h0096);
        `CHK(dt_lo >= 98 && dt_hi <= 100, 1'b1)
        $display("period cap test done");
    endtask

    task automatic t_abort;
        @(negedge i_core_clk);
        i_enable = 1'b0;
        repeat (5) step;
        `CHK(hs | ls | run, 1'b0)
        $display("abort test done");
    endtask

    initial begin
        repeat (16) @(negedge i_core_clk);
        i_resetn = 1'b1;
        step;
        t_startup;
        t_sync;
        t_sync_end;
        t_duty;
        t_dt_prompt;
        t_dt_slow;
        t_dt_cap;
        t_dt_period;
        t_abort;
        give_verdict;
    end

    initial begin
        repeat (40000) @(posedge i_core_clk);
        mismatches++;
        give_verdict;
    end
endmodule
